// ===== core/ssc_defs.vh
// Function
// - Interrupt enables at bits 6,5,4,3,2; all clear at reset.
// - Click enable set: detected click raises the interrupt request.
// - Motion enable set: X or Y movement raises the interrupt request in navigation mode only.
// - Read error enable set: detected read error raises the interrupt.
// - Reading the status register withdraws the pending interrupt.
// - Two test enables are stored only and steer nothing.
// - Heater power code 00 is 50 mW, 01 is 100 mW, others reserved.
// - Watchdog enabled: heater switches off after a time-out.
// - Navigation frame rate codes give 5.8, 2.9, 1.9, 1.5 kHz.
// - Navigation rate is the rate of reading one whole new frame.
// - Navigation pixel threshold code, 00 lowest, 11 highest.
// - Tap pixel threshold at bits 2,1, 00 lowest, 11 highest.
// - Tap sample rate codes give 180, 90, 60, 45 Hz.
// - Slice colour needs more than 7+n alike and fewer than 5-n opposite.
// - Tap slice limit codes map to 5,7,10,12,16,20,25,31 slices.
// - Click only when two transitions are closer than the slice limit.
// - Mode codes: click 0010, navigation 0100, acquisition 1000, both 0110.
// - Click sets status bit 7 and navigation bit 1; status read clears only status.
`ifndef SSC_DEFS_VH
`define SSC_DEFS_VH

`define SSC_ADDR_STATUS    4'h0
`define SSC_ADDR_IRQEN     4'h2
`define SSC_ADDR_HEATER    4'h3
`define SSC_ADDR_NAVSETUP  4'h4
`define SSC_ADDR_TAPSETUP  4'h5

`define SSC_WMASK_IRQEN    7'h7c
`define SSC_WMASK_HEATER   7'h7c
`define SSC_WMASK_NAV      7'h7e
`define SSC_WMASK_TAP      7'h7f

`define SSC_RST_IRQEN      7'h00
`define SSC_RST_HEATER     7'h00
`define SSC_RST_NAV        7'h20
`define SSC_RST_TAP        7'h2d

`define SSC_BIT_CLICK_IRQ_ENABLE    6
`define SSC_BIT_MOTION_IRQ_ENABLE      5
`define SSC_BIT_TRANSEN    4
`define SSC_BIT_SLICEEN    3
`define SSC_BIT_RDERREN    2
`define SSC_BIT_HEATER_SWITCH       6
`define SSC_BIT_WDOG       5

`define SSC_ST_CLICK       7
`define SSC_ST_MOTION      6
`define SSC_ST_RDERR       5

`define SSC_MODE_CLICK     4'h2
`define SSC_MODE_NAV       4'h4
`define SSC_MODE_ACQ       4'h8

`define SSC_PWR_50MW       2'h0
`define SSC_PWR_100MW      2'h1

`define SSC_CLK_HZ         100000000
`define SSC_NAV_F0_HZ      5800
`define SSC_NAV_F1_HZ      2900
`define SSC_NAV_F2_HZ      1900
`define SSC_NAV_F3_HZ      1500
`define SSC_TAP_F0_HZ      180
`define SSC_TAP_F1_HZ      90
`define SSC_TAP_F2_HZ      60
`define SSC_TAP_F3_HZ      45

`define SSC_COLOUR_BASE    5'h07
`define SSC_OPPOSITE_BASE  5'h05

`define SSC_LIMIT_0        5'h05
`define SSC_LIMIT_1        5'h07
`define SSC_LIMIT_2        5'h0a
`define SSC_LIMIT_3        5'h0c
`define SSC_LIMIT_4        5'h10
`define SSC_LIMIT_5        5'h14
`define SSC_LIMIT_6        5'h19
`define SSC_LIMIT_7        5'h1f

`define SSC_WDOG_CYCLES    100000

`endif

// ===== core/ssc_tap_detect.v
`timescale 1ns/1ps
`include "ssc_defs.vh"
module ssc_tap_detect (
   input  wire       clk,
   input  wire       srst,
   input  wire       enable,
   input  wire       sliceValid,
   input  wire [4:0] blackCount,
   input  wire [4:0] whiteCount,
   input  wire [1:0] colourThr,
   input  wire [2:0] sliceLimit,
   output reg        clickPulse
);

   function [4:0] limitOf;
      input [2:0] code;
      begin
         case (code)
            3'h0:    limitOf = `SSC_LIMIT_0;
            3'h1:    limitOf = `SSC_LIMIT_1;
            3'h2:    limitOf = `SSC_LIMIT_2;
            3'h3:    limitOf = `SSC_LIMIT_3;
            3'h4:    limitOf = `SSC_LIMIT_4;
            3'h5:    limitOf = `SSC_LIMIT_5;
            3'h6:    limitOf = `SSC_LIMIT_6;
            default: limitOf = `SSC_LIMIT_7;
         endcase
      end
   endfunction

   reg        colour_q;
   reg        colourKnown_q;
   reg        armed_q;
   reg  [4:0] gap_q;
   wire [4:0] alikeMin    = `SSC_COLOUR_BASE + {3'h0, colourThr};
   wire [4:0] oppositeMax = `SSC_OPPOSITE_BASE - {3'h0, colourThr};
   wire       isBlack     = (blackCount > alikeMin) && (whiteCount < oppositeMax);
   wire       isWhite     = (whiteCount > alikeMin) && (blackCount < oppositeMax);
   wire       classified  = isBlack || isWhite;
   wire       transition  = classified && colourKnown_q && (isBlack != colour_q);
   wire [4:0] limit       = limitOf(sliceLimit);

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      if (srst || !enable)
      begin
         colour_q      <= 1'b0;
         colourKnown_q <= 1'b0;
         armed_q       <= 1'b0;
         gap_q         <= 5'h00;
         clickPulse    <= 1'b0;
      end
      else
      begin
         clickPulse <= 1'b0;
         if (sliceValid)
         begin
            if (classified)
            begin
               colour_q      <= isBlack;
               colourKnown_q <= 1'b1;
            end
            if (transition)
            begin
               gap_q <= 5'h00;
               if (armed_q && (gap_q < limit))
               begin
                  clickPulse <= 1'b1;
                  armed_q    <= 1'b0;
               end
               else
                  armed_q <= 1'b1;
            end
            else if (gap_q < limit)
               gap_q <= gap_q + 5'h01;
            else
               armed_q <= 1'b0;
         end
      end
   end

endmodule // ssc_tap_detect

// ===== core/ssc_heater_wdog.v
`timescale 1ns/1ps
`include "ssc_defs.vh"
module ssc_heater_wdog #(
   parameter WDOG_CYCLES = `SSC_WDOG_CYCLES
) (
   input  wire       clk,
   input  wire       srst,
   input  wire       heaterSwitch,
   input  wire       wdogEnable,
   input  wire [1:0] powerLevel,
   input  wire       acqMode,
   input  wire       oscRunning,
   output reg        heaterOn,
   output reg        heaterHighPower
);

   reg  [31:0] count_q;
   reg         request_q;
   wire        powerOk = (powerLevel == `SSC_PWR_50MW) || (powerLevel == `SSC_PWR_100MW);
   wire        request = heaterSwitch && acqMode && powerOk;
   wire        expired = wdogEnable && (count_q >= WDOG_CYCLES);

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      if (srst)
      begin
         count_q         <= 32'h0;
         request_q       <= 1'b0;
         heaterOn        <= 1'b0;
         heaterHighPower <= 1'b0;
      end
      else
      begin
         request_q <= request;
         if (request && !request_q)
            count_q <= 32'h0;
         else if (request && oscRunning && !expired)
            count_q <= count_q + 32'h1;
         heaterOn        <= request && !expired;
         heaterHighPower <= request && !expired && (powerLevel == `SSC_PWR_100MW);
      end
   end

endmodule // ssc_heater_wdog

// ===== core/ssc_control_regs.v
`timescale 1ns/1ps
`include "ssc_defs.vh"
module ssc_control_regs #(
   parameter WDOG_CYCLES = `SSC_WDOG_CYCLES,
   parameter NAV_DIV0    = `SSC_CLK_HZ / `SSC_NAV_F0_HZ,
   parameter NAV_DIV1    = `SSC_CLK_HZ / `SSC_NAV_F1_HZ,
   parameter NAV_DIV2    = `SSC_CLK_HZ / `SSC_NAV_F2_HZ,
   parameter NAV_DIV3    = `SSC_CLK_HZ / `SSC_NAV_F3_HZ,
   parameter TAP_DIV0    = `SSC_CLK_HZ / `SSC_TAP_F0_HZ,
   parameter TAP_DIV1    = `SSC_CLK_HZ / `SSC_TAP_F1_HZ,
   parameter TAP_DIV2    = `SSC_CLK_HZ / `SSC_TAP_F2_HZ,
   parameter TAP_DIV3    = `SSC_CLK_HZ / `SSC_TAP_F3_HZ
) (
   input  wire       clk,
   input  wire       srst,
   input  wire       spiSck,
   input  wire       spiSsN,
   input  wire       spiMosi,
   output reg        spiMiso,
   output reg        spiMisoOe,
   input  wire [3:0] operatingMode,
   input  wire       oscRunning,
   input  wire       sliceValid,
   input  wire [4:0] sliceBlackCount,
   input  wire [4:0] sliceWhiteCount,
   input  wire       motionDetected,
   input  wire       readErrorDetected,
   input  wire       navPacketRead,
   output reg        irqOut,
   output reg        navClickFlag,
   output reg        navFrameStrobe,
   output reg        tapSampleStrobe,
   output reg  [1:0] navPixelThreshold,
   output reg  [1:0] tapPixelThreshold,
   output wire       heaterOn,
   output wire       heaterHighPower
);

   function [31:0] pickDiv;
      input [1:0]  code;
      input [31:0] d0;
      input [31:0] d1;
      input [31:0] d2;
      input [31:0] d3;
      begin
         case (code)
            2'h0:    pickDiv = d0;
            2'h1:    pickDiv = d1;
            2'h2:    pickDiv = d2;
            default: pickDiv = d3;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   reg  [1:0] sckSync_q;
   reg  [1:0] ssnSync_q;
   reg  [1:0] mosiSync_q;
   reg        sckLast_q;

   always @(posedge clk)
   begin
      if (srst)
      begin
         sckSync_q  <= 2'h3;
         ssnSync_q  <= 2'h3;
         mosiSync_q <= 2'h0;
         sckLast_q  <= 1'b1;
      end
      else
      begin
         sckSync_q  <= {sckSync_q[0], spiSck};
         ssnSync_q  <= {ssnSync_q[0], spiSsN};
         mosiSync_q <= {mosiSync_q[0], spiMosi};
         sckLast_q  <= sckSync_q[1];
      end
   end

   wire selected = !ssnSync_q[1];
   wire sckRise  = selected && sckSync_q[1] && !sckLast_q;
   wire sckFall  = selected && !sckSync_q[1] && sckLast_q;

   ////////////////////////////////////////////////////////////////////////////
   // Register storage
   reg  [6:0] irqEnable_q;
   reg  [6:0] heaterCtrl_q;
   reg  [6:0] navSetup_q;
   reg  [6:0] tapSetup_q;
   reg  [7:0] status_q;

   wire       clickMode = operatingMode[1] && !operatingMode[3];
   wire       navMode   = operatingMode[2] && !operatingMode[3];
   wire       acqMode   = (operatingMode == `SSC_MODE_ACQ);
   wire       clickEvent;

   ////////////////////////////////////////////////////////////////////////////
   // Serial frame: command byte {read, 3'h0, addr}, then data byte
   reg  [2:0] bitCnt_q;
   reg        dataPhase_q;
   reg        isRead_q;
   reg  [3:0] addr_q;
   reg  [7:0] rxShift_q;
   reg  [7:0] txShift_q;
   reg        wrStrobe_q;
   reg  [7:0] wrData_q;
   reg  [7:0] statusClear_q;
   wire [7:0] rxByte = {rxShift_q[6:0], mosiSync_q[1]};
   reg  [7:0] readData;

   always @*
   begin
      readData = 8'h00;
      case (rxByte[3:0])
         `SSC_ADDR_STATUS:   readData = status_q;
         `SSC_ADDR_IRQEN:    readData = {1'b0, irqEnable_q};
         `SSC_ADDR_HEATER:   readData = {1'b0, heaterCtrl_q};
         `SSC_ADDR_NAVSETUP: readData = {1'b0, navSetup_q};
         `SSC_ADDR_TAPSETUP: readData = {1'b0, tapSetup_q};
         default:            readData = 8'h00;
      endcase
   end

   always @(posedge clk)
   begin
      if (srst || !selected)
      begin
         bitCnt_q      <= 3'h0;
         dataPhase_q   <= 1'b0;
         isRead_q      <= 1'b0;
         addr_q        <= 4'h0;
         rxShift_q     <= 8'h00;
         txShift_q     <= 8'h00;
         wrStrobe_q    <= 1'b0;
         wrData_q      <= 8'h00;
         statusClear_q <= 8'h00;
      end
      else
      begin
         wrStrobe_q    <= 1'b0;
         statusClear_q <= 8'h00;
         if (sckFall && dataPhase_q)
            txShift_q <= {txShift_q[6:0], 1'b0};
         if (sckRise)
         begin
            rxShift_q <= rxByte;
            bitCnt_q  <= bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7)
            begin
               if (!dataPhase_q)
               begin
                  dataPhase_q <= 1'b1;
                  isRead_q    <= rxByte[7];
                  addr_q      <= rxByte[3:0];
                  txShift_q   <= rxByte[7] ? readData : 8'h00;
                  if (rxByte[7] && (rxByte[3:0] == `SSC_ADDR_STATUS))
                     statusClear_q <= status_q;
               end
               else
               begin
                  dataPhase_q <= 1'b0;
                  wrStrobe_q  <= !isRead_q;
                  wrData_q    <= rxByte;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output line, changes on falling clock edge
   always @(posedge clk)
   begin
      if (srst)
      begin
         spiMiso   <= 1'b0;
         spiMisoOe <= 1'b0;
      end
      else
      begin
         spiMisoOe <= selected;
         if (!selected)
            spiMiso <= 1'b0;
         else if (sckFall && dataPhase_q)
            spiMiso <= txShift_q[7];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes
   always @(posedge clk)
   begin
      if (srst)
      begin
         irqEnable_q  <= `SSC_RST_IRQEN;
         heaterCtrl_q <= `SSC_RST_HEATER;
         navSetup_q   <= `SSC_RST_NAV;
         tapSetup_q   <= `SSC_RST_TAP;
      end
      else if (wrStrobe_q)
      begin
         case (addr_q)
            `SSC_ADDR_IRQEN:    irqEnable_q  <= wrData_q[6:0] & `SSC_WMASK_IRQEN;
            `SSC_ADDR_HEATER:   heaterCtrl_q <= wrData_q[6:0] & `SSC_WMASK_HEATER;
            `SSC_ADDR_NAVSETUP: navSetup_q   <= wrData_q[6:0] & `SSC_WMASK_NAV;
            `SSC_ADDR_TAPSETUP: tapSetup_q   <= wrData_q[6:0] & `SSC_WMASK_TAP;
            default:            irqEnable_q  <= irqEnable_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags and interrupt request; a new event wins over the clear
   reg  [7:0] events;

   always @*
   begin
      events                 = 8'h00;
      events[`SSC_ST_CLICK]  = clickEvent;
      events[`SSC_ST_MOTION] = motionDetected && navMode;
      events[`SSC_ST_RDERR]  = readErrorDetected;
   end

   wire [7:0] statusNext = (status_q & ~statusClear_q) | events;
   wire [7:0] irqMask    = {irqEnable_q[`SSC_BIT_CLICK_IRQ_ENABLE],
                            irqEnable_q[`SSC_BIT_MOTION_IRQ_ENABLE],
                            irqEnable_q[`SSC_BIT_RDERREN], 5'h00};

   always @(posedge clk)
   begin
      if (srst)
      begin
         status_q     <= 8'h00;
         irqOut       <= 1'b0;
         navClickFlag <= 1'b0;
      end
      else
      begin
         status_q     <= statusNext;
         irqOut       <= |(statusNext & irqMask);
         navClickFlag <= clickEvent || (navClickFlag && !navPacketRead);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame and sample rate timers
   reg  [31:0] navCnt_q;
   reg  [31:0] tapCnt_q;
   wire [31:0] navDiv = pickDiv(navSetup_q[6:5], NAV_DIV0, NAV_DIV1, NAV_DIV2, NAV_DIV3);
   wire [31:0] tapDiv = pickDiv(tapSetup_q[6:5], TAP_DIV0, TAP_DIV1, TAP_DIV2, TAP_DIV3);

   always @(posedge clk)
   begin
      if (srst)
      begin
         navCnt_q          <= 32'h0;
         tapCnt_q          <= 32'h0;
         navFrameStrobe    <= 1'b0;
         tapSampleStrobe   <= 1'b0;
         navPixelThreshold <= 2'h0;
         tapPixelThreshold <= 2'h0;
      end
      else
      begin
         navFrameStrobe    <= 1'b0;
         tapSampleStrobe   <= 1'b0;
         navPixelThreshold <= navSetup_q[4:3];
         tapPixelThreshold <= navSetup_q[2:1];
         if (!navMode || (navCnt_q >= navDiv - 32'h1))
         begin
            navCnt_q       <= 32'h0;
            navFrameStrobe <= navMode;
         end
         else
            navCnt_q <= navCnt_q + 32'h1;
         if (!clickMode || (tapCnt_q >= tapDiv - 32'h1))
         begin
            tapCnt_q        <= 32'h0;
            tapSampleStrobe <= clickMode;
         end
         else
            tapCnt_q <= tapCnt_q + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tap detector and heater watchdog; test enables at bits 4 and 3 are stored only
   ssc_tap_detect u_tap (
      .clk        (clk),
      .srst       (srst),
      .enable     (clickMode),
      .sliceValid (sliceValid),
      .blackCount (sliceBlackCount),
      .whiteCount (sliceWhiteCount),
      .colourThr  (tapSetup_q[4:3]),
      .sliceLimit (tapSetup_q[2:0]),
      .clickPulse (clickEvent)
   );

   ssc_heater_wdog #(
      .WDOG_CYCLES (WDOG_CYCLES)
   ) u_heater_switch (
      .clk             (clk),
      .srst            (srst),
      .heaterSwitch    (heaterCtrl_q[`SSC_BIT_HEATER_SWITCH]),
      .wdogEnable      (heaterCtrl_q[`SSC_BIT_WDOG]),
      .powerLevel      (heaterCtrl_q[4:3]),
      .acqMode         (acqMode),
      .oscRunning      (oscRunning),
      .heaterOn        (heaterOn),
      .heaterHighPower (heaterHighPower)
   );

endmodule // ssc_control_regs

// ===== verif/ssc_monitor.sv
`timescale 1ns/1ps
module ssc_monitor (
   input wire       clk,
   input wire       srst,
   input wire       spiSsN,
   input wire [3:0] operatingMode,
   input wire       sliceValid,
   input wire       motionDetected,
   input wire       readErrorDetected,
   input wire       navPacketRead,
   input wire       irqOut,
   input wire       navClickFlag,
   input wire       navFrameStrobe,
   input wire       tapSampleStrobe,
   input wire [1:0] navPixelThreshold,
   input wire [1:0] tapPixelThreshold,
   input wire       heaterOn,
   input wire       heaterHighPower
);
   ////////////////////////////////////////////////////////////////////////
   // Cycles since the host last selected the block
   reg  [4:0] idleCnt_q;
   wire       spiRecent = idleCnt_q < 5'h08;
   always @(posedge clk)
      if (srst || !spiSsN)
         idleCnt_q <= 5'h00;
      else if (idleCnt_q != 5'h1f)
         idleCnt_q <= idleCnt_q + 5'h01;
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_nav_pulse;
      navFrameStrobe ##1 !navFrameStrobe;
   endsequence
   property p_heater_switch_acq;
      heaterOn |-> $past(operatingMode) == 4'h8;
   endproperty
   property p_high_power;
      heaterHighPower |-> heaterOn;
   endproperty
   property p_nav_strobe;
      navFrameStrobe |-> $past(operatingMode[2]) ##0 s_nav_pulse;
   endproperty
   property p_tap_strobe;
      tapSampleStrobe |-> $past(operatingMode[1]);
   endproperty
   property p_irq_rise;
      $rose(irqOut) |-> $past(motionDetected) || $past(readErrorDetected)
         || $past(sliceValid, 2) || spiRecent;
   endproperty
   property p_irq_fall;
      $fell(irqOut) |-> spiRecent;
   endproperty
   property p_flag_set;
      $rose(navClickFlag) |-> $past(sliceValid, 2);
   endproperty
   property p_flag_clear;
      navPacketRead && !$past(sliceValid) |=> !navClickFlag;
   endproperty
   property p_nav_thr;
      $changed(navPixelThreshold) |-> spiRecent;
   endproperty
   property p_tap_thr;
      $changed(tapPixelThreshold) |-> spiRecent;
   endproperty
   a_heater_switch_acq: assert property (p_heater_switch_acq) else $error("heater on outside acq");
   a_high_power: assert property (p_high_power) else $error("power without heater_switch");
   a_nav_strobe: assert property (p_nav_strobe) else $error("bad nav strobe");
   a_tap_strobe: assert property (p_tap_strobe) else $error("bad tap strobe");
   a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
   a_flag_set: assert property (p_flag_set) else $error("click flag no cause");
   a_flag_clear: assert property (p_flag_clear) else $error("click flag kept");
   a_nav_thr: assert property (p_nav_thr) else $error("nav threshold moved");
   a_tap_thr: assert property (p_tap_thr) else $error("tap threshold moved");
endmodule // ssc_monitor

bind ssc_control_regs ssc_monitor ssc_monitor_i (
   .clk               (clk),
   .srst              (srst),
   .spiSsN            (spiSsN),
   .operatingMode     (operatingMode),
   .sliceValid        (sliceValid),
   .motionDetected    (motionDetected),
   .readErrorDetected (readErrorDetected),
   .navPacketRead     (navPacketRead),
   .irqOut            (irqOut),
   .navClickFlag      (navClickFlag),
   .navFrameStrobe    (navFrameStrobe),
   .tapSampleStrobe   (tapSampleStrobe),
   .navPixelThreshold (navPixelThreshold),
   .tapPixelThreshold (tapPixelThreshold),
   .heaterOn          (heaterOn),
   .heaterHighPower   (heaterHighPower)
);

// ===== verif/ssc_spi_host.sv
`timescale 1ns/1ps
module ssc_spi_host (
   output logic sck,
   output logic ssN,
   output logic mosi,
   input  wire  miso
);
   localparam int HALF = 40;
   initial
   begin
      sck = 1'b1;
      ssN = 1'b1;
      mosi = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Two-byte frame, idle-high clock, MSB first, clock still between frames
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
                       output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, dat};
      ssN = 1'b0;
      #HALF;
      for (int i = 15; i >= 0; i--)
      begin
         sck = 1'b0;
         mosi = sh[i];
         #HALF;
         sck = 1'b1;
         #HALF;
         if (i < 8)
            rd[i] = miso;
      end
      ssN = 1'b1;
      mosi = ~mosi;
      #(4 * HALF);
   endtask
endmodule // ssc_spi_host

// ===== verif/ssc_control_regs_test.sv
`timescale 1ns/1ps
`include "ssc_defs.vh"
module ssc_control_regs_test;
   localparam int WDOG = 50, ND = 20, TD = 30;
   logic       clk, srst, spiSck, spiSsN, spiMosi, spiMiso, spiMisoOe;
   logic       oscRunning, sliceValid, motionDetected, readErrorDetected;
   logic       navPacketRead, irqOut, navClickFlag, navFrameStrobe;
   logic       tapSampleStrobe, heaterOn, heaterHighPower;
   logic [3:0] operatingMode;
   logic [4:0] sliceBlackCount, sliceWhiteCount;
   logic [1:0] navPixelThreshold, tapPixelThreshold;
   int         errorCnt = 0;
   int         numChecks = 0;
   logic [3:0] regAdr [4] = '{`SSC_ADDR_IRQEN, `SSC_ADDR_HEATER,
                              `SSC_ADDR_NAVSETUP, `SSC_ADDR_TAPSETUP};
   logic [7:0] regRst [4] = '{8'h00, 8'h00, 8'h20, 8'h2d};
   logic [7:0] regMsk [4] = '{8'h7c, 8'h7c, 8'h7e, 8'h7f};

   ssc_control_regs #(
      .WDOG_CYCLES (WDOG),
      .NAV_DIV0    (ND),
      .NAV_DIV1    (ND * 2),
      .NAV_DIV2    (ND * 3),
      .NAV_DIV3    (ND * 4),
      .TAP_DIV0    (TD),
      .TAP_DIV1    (TD * 2),
      .TAP_DIV2    (TD * 3),
      .TAP_DIV3    (TD * 4)
   ) ssc_control_regs_i (
      .clk               (clk),
      .srst              (srst),
      .spiSck            (spiSck),
      .spiSsN            (spiSsN),
      .spiMosi           (spiMosi),
      .spiMiso           (spiMiso),
      .spiMisoOe         (spiMisoOe),
      .operatingMode     (operatingMode),
      .oscRunning        (oscRunning),
      .sliceValid        (sliceValid),
      .sliceBlackCount   (sliceBlackCount),
      .sliceWhiteCount   (sliceWhiteCount),
      .motionDetected    (motionDetected),
      .readErrorDetected (readErrorDetected),
      .navPacketRead     (navPacketRead),
      .irqOut            (irqOut),
      .navClickFlag      (navClickFlag),
      .navFrameStrobe    (navFrameStrobe),
      .tapSampleStrobe   (tapSampleStrobe),
      .navPixelThreshold (navPixelThreshold),
      .tapPixelThreshold (tapPixelThreshold),
      .heaterOn          (heaterOn),
      .heaterHighPower   (heaterHighPower)
   );
   ssc_spi_host ssc_spi_host_i (
      .sck  (spiSck),
      .ssN  (spiSsN),
      .mosi (spiMosi),
      .miso (spiMiso)
   );
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      numChecks++;
      if (seen !== exp)
      begin
         errorCnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic chk1(input logic seen, input logic exp);
      check({7'h00, seen}, {7'h00, exp});
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] r;
      ssc_spi_host_i.xfer({4'h0, a}, d, r);
   endtask
   task automatic rdChk(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] r;
      ssc_spi_host_i.xfer({4'h8, a}, 8'h00, r);
      check(r, e);
   endtask
   task automatic slice(input logic [4:0] b, input logic [4:0] w);
      sliceBlackCount = b;
      sliceWhiteCount = w;
      sliceValid = 1'b1;
      cyc(1);
      sliceValid = 1'b0;
      cyc(3);
   endtask
   task automatic period(input bit tap, input int exp);
      int n;
      n = 0;
      while ((tap ? tapSampleStrobe : navFrameStrobe) !== 1'b1 && n < 300)
      begin
         cyc(1);
         n++;
      end
      n = 0;
      do
      begin
         cyc(1);
         n++;
      end while ((tap ? tapSampleStrobe : navFrameStrobe) !== 1'b1 && n < 300);
      check(8'(n), 8'(exp));
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic tRegs();
      for (int i = 0; i < 4; i++)
         rdChk(regAdr[i], regRst[i]);
      for (int i = 0; i < 4; i++)
      begin
         wr(regAdr[i], 8'hff);
         rdChk(regAdr[i], regMsk[i]);
         wr(regAdr[i], 8'h00);
         rdChk(regAdr[i], 8'h00);
      end
      fork
         wr(`SSC_ADDR_NAVSETUP, 8'h5c);
         begin
            cyc(5);
            chk1(spiMisoOe, 1'b1);
         end
      join
      chk1(spiMisoOe, 1'b0);
      check({6'h00, navPixelThreshold}, 8'h03);
      check({6'h00, tapPixelThreshold}, 8'h02);
      rdChk(4'hf, 8'h00);
      $display("tRegs done");
   endtask
   task automatic tIrq();
      logic [7:0] en, st;
      operatingMode = `SSC_MODE_NAV;
      for (int k = 0; k < 4; k++)
      begin
         en = k[0] ? 8'h04 : 8'h20;
         st = k[0] ? 8'h20 : 8'h40;
         wr(`SSC_ADDR_IRQEN, k[1] ? en : 8'h00);
         motionDetected = !k[0];
         readErrorDetected = k[0];
         cyc(1);
         motionDetected = 1'b0;
         readErrorDetected = 1'b0;
         cyc(2);
         chk1(irqOut, k[1]);
         rdChk(`SSC_ADDR_STATUS, st);
         chk1(irqOut, 1'b0);
      end
      $display("tIrq done");
   endtask
   task automatic tTap();
      operatingMode = `SSC_MODE_CLICK;
      wr(`SSC_ADDR_IRQEN, 8'h40);
      wr(`SSC_ADDR_TAPSETUP, 8'h00);
      repeat (8) slice(5'h00, 5'h14);
      slice(5'h08, 5'h05);
      slice(5'h00, 5'h14);
      chk1(irqOut, 1'b0);
      repeat (6) slice(5'h14, 5'h00);
      slice(5'h00, 5'h14);
      chk1(irqOut, 1'b0);
      slice(5'h14, 5'h00);
      chk1(irqOut, 1'b1);
      chk1(navClickFlag, 1'b1);
      rdChk(`SSC_ADDR_STATUS, 8'h80);
      chk1(irqOut, 1'b0);
      chk1(navClickFlag, 1'b1);
      navPacketRead = 1'b1;
      cyc(1);
      navPacketRead = 1'b0;
      cyc(1);
      chk1(navClickFlag, 1'b0);
      $display("tTap done");
   endtask
   task automatic tHeat();
      operatingMode = `SSC_MODE_ACQ;
      wr(`SSC_ADDR_HEATER, 8'h48);
      chk1(heaterOn, 1'b1);
      chk1(heaterHighPower, 1'b1);
      cyc(WDOG + 10);
      chk1(heaterOn, 1'b1);
      operatingMode = `SSC_MODE_NAV;
      cyc(2);
      chk1(heaterOn, 1'b0);
      operatingMode = `SSC_MODE_ACQ;
      wr(`SSC_ADDR_HEATER, 8'h50);
      chk1(heaterOn, 1'b0);
      wr(`SSC_ADDR_HEATER, 8'h60);
      chk1(heaterOn, 1'b1);
      chk1(heaterHighPower, 1'b0);
      cyc(25);
      chk1(heaterOn, 1'b1);
      cyc(30);
      chk1(heaterOn, 1'b0);
      wr(`SSC_ADDR_HEATER, 8'h00);
      $display("tHeat done");
   endtask
   task automatic tRate();
      for (int k = 0; k < 8; k++)
      begin
         operatingMode = 4'h0;
         wr(k[2] ? `SSC_ADDR_TAPSETUP : `SSC_ADDR_NAVSETUP, {1'b0, k[1:0], 5'h00});
         operatingMode = k[2] ? `SSC_MODE_CLICK : `SSC_MODE_NAV;
         period(k[2], (k[2] ? TD : ND) * (k % 4 + 1));
      end
      $display("tRate done");
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", numChecks, errorCnt);
      if (errorCnt == 0 && numChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      srst = 1'b1;
      oscRunning = 1'b1;
      operatingMode = 4'h0;
      sliceValid = 1'b0;
      sliceBlackCount = 5'h00;
      sliceWhiteCount = 5'h00;
      motionDetected = 1'b0;
      readErrorDetected = 1'b0;
      navPacketRead = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      srst = 1'b0;
      cyc(3);
      tRegs();
      tIrq();
      tTap();
      tHeat();
      tRate();
      results();
   end
   // Some five times the expected run
   initial
   begin
      repeat (40000) @(posedge clk);
      errorCnt++;
      results();
   end
endmodule // ssc_control_regs_test
